// File: rtl/lnur_core.sv
// lin/uart response engine, length fields, flags and checksum
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`include "lnur_regs.svh"
// Summary of operation
// - resync disable freezes and unlocks sample count
// - rx response counts received bytes in tx length
// - tx response counts sent bytes in rx length
// - zero length means checksum only; clamp to eight outside lin 1.3
// - lin 1.3 lengths decoded from identifier
// - uart mode and reset force lengths zero
// - ok flags set at header, response, character
// - summary is or of errors; write clears
// - echo mismatch flags bit error, aborts transmit
// - checksum error when sum check misses 0xff
// - parity error flagged, no correction attempted
// - sync field edge error flagged
// - dominant stop bit flags framing error
// - frame time-out flagged
// - command while busy flags overrun
// - abort while busy sets abort flag
// - lin error stops and returns command idle
// - break in data aborts and flags error
// - inverted end-around-carry checksum, enhanced or classic
// - enabled status flags drive two interrupts
// - protocol select chooses checksum type
module lnur_core
  import lnur_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  output logic            txd,
  input  wire logic       rxd,
  input  wire logic       hdr_done,
  input  wire logic [7:0] hdr_pid,
  input  wire logic       hdr_busy,
  input  wire logic       sync_err_evt,
  input  wire logic       timeout_evt,
  input  wire logic       brk_sync_evt,
  input  wire logic       resync_valid,
  input  wire logic [5:0] resync_spb,
  output logic            hdr_tx_start,
  output logic      [2:0] rsp_idx,
  input  wire logic [7:0] rsp_tx_data,
  output logic      [7:0] rsp_rx_data,
  output logic      [2:0] rsp_rx_idx,
  output logic            rsp_rx_wr,
  output logic            irq_comm,
  output logic            irq_err
);

  function automatic logic [7:0] add8c(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic pid_ok(input logic [7:0] p);
    return (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4])) &&
           (p[7] == !(p[1] ^ p[3] ^ p[4] ^ p[5]));
  endfunction

  function automatic logic [3:0] len13(input logic [7:0] p);
    return p[5] ? (p[4] ? 4'h8 : 4'h4) : 4'h2;
  endfunction

  function automatic logic [3:0] clamp8(input logic [3:0] l);
    return (l > `LNUR_MAX_LEN) ? `LNUR_MAX_LEN : l;
  endfunction

  lnur_rsp_e  rsp_q;
  logic [2:0] cmd_q;
  logic [3:0] rxl_q, txl_q;
  logic [7:0] sum_q, pid_q, ubuf_q, err_q;
  logic       chk_q, go_q, abt_q;
  logic       proto_q, ena_q;
  logic [1:0] conf_q;
  logic       idok_q, rxok_q, txok_q;
  logic [3:0] iren_q;
  logic       dis_q;
  logic [5:0] spb_q;
  logic [3:0] div_q;
  logic       tx_act_q, rx_act_q, txd_q;
  logic [5:0] tx_smp_q, rx_smp_q;
  logic [3:0] tx_bit_q, rx_bit_q;
  logic [9:0] tx_sh_q;
  logic [7:0] rx_sh_q;

  logic       smp_en, uart, busy, err_sum;
  logic       soft_clr, kill_all, cmd_wr, lin_err;
  logic       tx_go, tx_end, tx_mid, tx_mis, tx_kill;
  logic [7:0] tx_byte, sum_nx;
  logic       rx_en, rx_mid, rx_stop, rx_good;
  logic       u_tx_start, u_rd;
  logic       bit_ev, frm_ev, cks_ev, par_ev, ovr_ev, abt_ev;
  logic       cks_byte, rx_ok_ev, tx_ok_ev;
  logic [5:0] spb_m1;
  logic [7:0] err_ev;

  assign uart     = cmd_q[2];
  assign busy     = (rsp_q != LNUR_R_IDLE) || hdr_busy || tx_act_q ||
                    (cmd_q == `LNUR_CMD_TXHDR);
  assign err_sum  = |err_q;
  assign soft_clr = wr_en && (addr == `LNUR_A_CTRL) && wdata[`LNUR_CTRL_SWRES];
  // disabling the controller kills at once, unlike abort
  assign kill_all = soft_clr || (wr_en && (addr == `LNUR_A_CTRL) && !wdata[`LNUR_CTRL_ENA]);
  assign cmd_wr   = wr_en && (addr == `LNUR_A_CTRL) && !kill_all;
  assign spb_m1   = spb_q - 6'h01;

  // sample tick divider; bit length is spb_q ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      div_q <= 4'h0;
    else if (smp_en)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end
  assign smp_en = (div_q == (`LNUR_SMP_DIV - 4'h1));

  assign u_tx_start = wr_en && (addr == `LNUR_A_DATA) && uart && cmd_q[1] && !tx_act_q;
  assign u_rd       = rd_en && (addr == `LNUR_A_DATA) && uart;
  assign tx_go      = go_q || u_tx_start;
  assign tx_byte    = u_tx_start ? wdata : (chk_q ? ~sum_q : rsp_tx_data);
  assign tx_mid     = tx_act_q && smp_en && (tx_smp_q == {1'b0, spb_q[5:1]});
  assign tx_end     = tx_act_q && smp_en && (tx_smp_q == spb_m1) && (tx_bit_q == `LNUR_STOP_BIT);
  assign tx_mis     = tx_mid && (rxd != txd_q) && (rsp_q == LNUR_R_TX);
  assign tx_kill    = kill_all || ((rsp_q == LNUR_R_TX) && lin_err);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_act_q <= 1'b0;
      tx_smp_q <= 6'h00;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 10'h3ff;
      txd_q    <= 1'b1;
    end else if (tx_kill) begin
      tx_act_q <= 1'b0;
      txd_q    <= 1'b1;
    end else if (tx_go) begin
      tx_act_q <= 1'b1;
      tx_smp_q <= 6'h00;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= {1'b1, tx_byte, 1'b0};
      txd_q    <= 1'b0;
    end else if (tx_act_q && smp_en) begin
      if (tx_smp_q == spb_m1) begin
        tx_smp_q <= 6'h00;
        tx_bit_q <= tx_bit_q + 4'h1;
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        txd_q    <= (tx_bit_q == `LNUR_STOP_BIT) ? 1'b1 : tx_sh_q[1];
        if (tx_bit_q == `LNUR_STOP_BIT)
          tx_act_q <= 1'b0;
      end else begin
        tx_smp_q <= tx_smp_q + 6'h01;
      end
    end
  end
  assign txd = txd_q;

  assign rx_en   = (rsp_q == LNUR_R_RX) || (uart && cmd_q[0]);
  assign rx_mid  = rx_act_q && smp_en && (rx_smp_q == {1'b0, spb_q[5:1]});
  assign rx_stop = rx_mid && (rx_bit_q == `LNUR_STOP_BIT);
  assign rx_good = rx_stop && rxd;

  // mid-bit sampling needs the sample count kept at eight or more
  // relies on software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_act_q <= 1'b0;
      rx_smp_q <= 6'h00;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 8'h00;
    end else if (!rx_en || kill_all) begin
      rx_act_q <= 1'b0;
    end else if (smp_en) begin
      if (!rx_act_q) begin
        rx_act_q <= !rxd;
        rx_smp_q <= 6'h00;
        rx_bit_q <= 4'h0;
      end else begin
        rx_smp_q <= (rx_smp_q == spb_m1) ? 6'h00 : rx_smp_q + 6'h01;
        if (rx_smp_q == spb_m1)
          rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_mid && (rx_bit_q == 4'h0) && rxd)
          rx_act_q <= 1'b0;
        if (rx_mid && (rx_bit_q != 4'h0) && (rx_bit_q != `LNUR_STOP_BIT))
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        if (rx_stop)
          rx_act_q <= 1'b0;
      end
    end
  end

  assign cks_byte = (rsp_q == LNUR_R_RX) && (txl_q == rxl_q);
  assign sum_nx   = add8c(sum_q, (rsp_q == LNUR_R_RX) ? rx_sh_q : rsp_tx_data);
  assign bit_ev   = tx_mis || ((rsp_q == LNUR_R_TX) && brk_sync_evt);
  assign frm_ev   = (rx_stop && !rxd && ((rsp_q == LNUR_R_RX) || uart)) ||
                    ((rsp_q == LNUR_R_RX) && brk_sync_evt);
  assign cks_ev   = cks_byte && rx_good && (sum_nx != `LNUR_CKS_GOOD);
  assign par_ev   = hdr_done && !uart && !pid_ok(hdr_pid);
  assign ovr_ev   = (cmd_wr && busy && (wdata[2:0] != `LNUR_CMD_ABORT) && (wdata[2:0] != cmd_q)) ||
                    (uart && rx_stop && rxok_q);
  assign abt_ev   = cmd_wr && busy && (wdata[2:0] == `LNUR_CMD_ABORT);
  assign lin_err  = !uart && (bit_ev || frm_ev || cks_ev || par_ev || sync_err_evt || timeout_evt);
  assign rx_ok_ev = (cks_byte && rx_good && !abt_q && !lin_err) || (uart && rx_stop);
  assign tx_ok_ev = (tx_end && (((rsp_q == LNUR_R_TX) && chk_q && !abt_q && !lin_err) || uart));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q        <= LNUR_R_IDLE;
      cmd_q        <= `LNUR_CMD_ABORT;
      rxl_q        <= 4'h0;
      txl_q        <= 4'h0;
      sum_q        <= 8'h00;
      chk_q        <= 1'b0;
      go_q         <= 1'b0;
      abt_q        <= 1'b0;
      hdr_tx_start <= 1'b0;
      rsp_rx_wr    <= 1'b0;
      rsp_rx_data  <= 8'h00;
      rsp_rx_idx   <= 3'h0;
    end else begin
      go_q         <= 1'b0;
      hdr_tx_start <= 1'b0;
      rsp_rx_wr    <= 1'b0;
      if (kill_all) begin
        rsp_q <= LNUR_R_IDLE;
        cmd_q <= `LNUR_CMD_ABORT;
        abt_q <= 1'b0;
        if (soft_clr) begin
          rxl_q <= 4'h0;
          txl_q <= 4'h0;
        end
      end else if (lin_err) begin
        rsp_q <= LNUR_R_IDLE;
        cmd_q <= `LNUR_CMD_ABORT;
        abt_q <= 1'b0;
      end else begin
        if (wr_en && (addr == `LNUR_A_LEN) && !uart && !busy) begin
          rxl_q <= wdata[3:0];
          txl_q <= wdata[7:4];
        end
        if (hdr_done && !uart) begin
          if (proto_q) begin
            rxl_q <= len13(hdr_pid);
            txl_q <= len13(hdr_pid);
          end
          if (cmd_q == `LNUR_CMD_TXHDR)
            cmd_q <= `LNUR_CMD_ABORT;
        end
        if (cmd_wr && !busy) begin
          cmd_q <= wdata[2:0];
          abt_q <= 1'b0;
          sum_q <= wdata[`LNUR_CTRL_PROTO] ? 8'h00 : pid_q;
          unique case (wdata[2:0])
            `LNUR_CMD_TXHDR: hdr_tx_start <= 1'b1;
            `LNUR_CMD_RXRSP: begin
              rsp_q <= LNUR_R_RX;
              txl_q <= 4'h0;
              rxl_q <= wdata[`LNUR_CTRL_PROTO] ? rxl_q : clamp8(rxl_q);
            end
            `LNUR_CMD_TXRSP: begin
              rsp_q <= LNUR_R_TX;
              rxl_q <= 4'h0;
              txl_q <= wdata[`LNUR_CTRL_PROTO] ? txl_q : clamp8(txl_q);
              chk_q <= (txl_q == 4'h0);
              go_q  <= 1'b1;
            end
            default: ;
          endcase
        end else if (abt_ev) begin
          abt_q <= 1'b1;
        end
        if ((rsp_q == LNUR_R_TX) && tx_end) begin
          if (abt_q || chk_q) begin
            rsp_q <= LNUR_R_IDLE;
            cmd_q <= `LNUR_CMD_ABORT;
            abt_q <= 1'b0;
          end else begin
            rxl_q <= rxl_q + 4'h1;
            sum_q <= sum_nx;
            chk_q <= ((rxl_q + 4'h1) == txl_q);
            go_q  <= 1'b1;
          end
        end
        if ((rsp_q == LNUR_R_RX) && rx_good) begin
          if (abt_q || cks_byte) begin
            rsp_q <= LNUR_R_IDLE;
            cmd_q <= `LNUR_CMD_ABORT;
            abt_q <= 1'b0;
          end else begin
            txl_q       <= txl_q + 4'h1;
            sum_q       <= sum_nx;
            rsp_rx_data <= rx_sh_q;
            rsp_rx_idx  <= txl_q[2:0];
            rsp_rx_wr   <= 1'b1;
          end
        end
        if (uart) begin
          rxl_q <= 4'h0;
          txl_q <= 4'h0;
        end
      end
    end
  end
  assign rsp_idx = rxl_q[2:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      proto_q <= 1'b0;
      conf_q  <= 2'h0;
      ena_q   <= 1'b0;
    end else if (soft_clr) begin
      proto_q <= 1'b0;
      conf_q  <= 2'h0;
      ena_q   <= 1'b0;
    end else if (wr_en && (addr == `LNUR_A_CTRL)) begin
      ena_q <= wdata[`LNUR_CTRL_ENA];
      // protocol and configuration locked while busy
      if (!busy) begin
        proto_q <= wdata[`LNUR_CTRL_PROTO];
        conf_q  <= wdata[5:4];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pid_q <= `LNUR_PID_RST;
    else if (soft_clr)
      pid_q <= `LNUR_PID_RST;
    else if (hdr_done && !uart)
      pid_q <= hdr_pid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ubuf_q <= 8'h00;
    else if (uart && rx_stop)
      ubuf_q <= rx_sh_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idok_q <= 1'b0;
      rxok_q <= 1'b0;
      txok_q <= 1'b0;
    end else if (soft_clr) begin
      idok_q <= 1'b0;
      rxok_q <= 1'b0;
      txok_q <= 1'b0;
    end else begin
      idok_q <= (hdr_done && !uart) ||
                (idok_q && !(wr_en && (addr == `LNUR_A_STAT) && wdata[`LNUR_ST_IDOK]));
      rxok_q <= rx_ok_ev ||
                (rxok_q && !u_rd && !(wr_en && (addr == `LNUR_A_STAT) && wdata[`LNUR_ST_RXOK]));
      txok_q <= tx_ok_ev ||
                (txok_q && !u_tx_start && !(wr_en && (addr == `LNUR_A_STAT) && wdata[`LNUR_ST_TXOK]));
    end
  end

  always_comb begin
    err_ev             = 8'h00;
    err_ev[`LNUR_E_BIT] = bit_ev;
    err_ev[`LNUR_E_CKS] = cks_ev;
    err_ev[`LNUR_E_PAR] = par_ev;
    err_ev[`LNUR_E_SYN] = sync_err_evt && !uart;
    err_ev[`LNUR_E_FRM] = frm_ev;
    err_ev[`LNUR_E_TO]  = timeout_evt && !uart;
    err_ev[`LNUR_E_OVR] = ovr_ev;
    err_ev[`LNUR_E_ABT] = abt_ev;
  end

  // summary write clears all, new events still win
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      err_q <= 8'h00;
    else if (soft_clr)
      err_q <= 8'h00;
    else if (wr_en && (addr == `LNUR_A_STAT) && wdata[`LNUR_ST_ERR])
      err_q <= err_ev;
    else
      err_q <= err_q | err_ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      iren_q <= 4'h0;
    else if (soft_clr)
      iren_q <= 4'h0;
    else if (wr_en && (addr == `LNUR_A_IREN))
      iren_q <= wdata[3:0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dis_q <= 1'b0;
      spb_q <= `LNUR_SPB_RST;
    end else if (soft_clr) begin
      dis_q <= 1'b0;
      spb_q <= `LNUR_SPB_RST;
    end else if (wr_en && (addr == `LNUR_A_BTIM)) begin
      dis_q <= wdata[`LNUR_BT_DIS];
      if (wdata[`LNUR_BT_DIS])
        spb_q <= wdata[5:0];
    end else if (!dis_q) begin
      if (resync_valid)
        spb_q <= resync_spb;
      else if (!uart && (rx_ok_ev || tx_ok_ev || lin_err))
        spb_q <= `LNUR_SPB_RST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        `LNUR_A_CTRL: rdata <= {1'b0, proto_q, conf_q, ena_q, cmd_q};
        `LNUR_A_STAT: rdata <= {3'h0, busy, err_sum, idok_q, txok_q, rxok_q};
        `LNUR_A_IREN: rdata <= {4'h0, iren_q};
        `LNUR_A_ERR:  rdata <= err_q;
        `LNUR_A_BTIM: rdata <= {dis_q, 1'b0, spb_q};
        `LNUR_A_LEN:  rdata <= {txl_q, rxl_q};
        `LNUR_A_PID:  rdata <= pid_q;
        `LNUR_A_DATA: rdata <= ubuf_q;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  assign irq_comm = (idok_q && iren_q[`LNUR_ST_IDOK]) || (txok_q && iren_q[`LNUR_ST_TXOK]) ||
                    (rxok_q && iren_q[`LNUR_ST_RXOK]);
  assign irq_err  = err_sum && iren_q[`LNUR_ST_ERR];

  err_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `LNUR_A_STAT && wdata[`LNUR_ST_ERR] && err_ev == 8'h00) |=> !err_sum)
    else $error("error summary write did not clear errors");
  err_sum_rd_a: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == `LNUR_A_STAT) |=> (rdata[`LNUR_ST_ERR] == |$past(err_q)))
    else $error("summary bit differs from error or");
  uart_len_a: assert property (@(posedge clk) disable iff (rst)
    $past(uart) && uart |-> (rxl_q == 4'h0 && txl_q == 4'h0))
    else $error("length fields nonzero in uart mode");
  idok_uart_a: assert property (@(posedge clk) disable iff (rst)
    $rose(idok_q) |-> !$past(uart))
    else $error("identifier ok set in uart mode");
  len_clamp_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && !busy && !lin_err && !wdata[`LNUR_CTRL_PROTO] && wdata[2:0] == `LNUR_CMD_RXRSP) |=> (rxl_q <= `LNUR_MAX_LEN))
    else $error("receive length not clamped");
  bit_abort_a: assert property (@(posedge clk) disable iff (rst)
    (bit_ev && !kill_all) |=> (rsp_q == LNUR_R_IDLE && cmd_q == `LNUR_CMD_ABORT && err_q[`LNUR_E_BIT]))
    else $error("bit error did not abort transmit");
  ovr_flag_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && busy && wdata[2:0] != `LNUR_CMD_ABORT && wdata[2:0] != cmd_q && !soft_clr)
    |=> (err_q[`LNUR_E_OVR] && cmd_q != $past(wdata[2:0])))
    else $error("busy command not flagged as overrun");
  abort_flag_a: assert property (@(posedge clk) disable iff (rst)
    abt_ev |=> err_q[`LNUR_E_ABT])
    else $error("abort while busy not flagged");
  spb_lock_a: assert property (@(posedge clk) disable iff (rst)
    (dis_q && !(wr_en && addr == `LNUR_A_BTIM) && !soft_clr) |=> $stable(spb_q))
    else $error("sample count moved while resync disabled");
  rx_len_a: assert property (@(posedge clk) disable iff (rst)
    (rsp_q == LNUR_R_RX && $past(rsp_q) == LNUR_R_RX && !$past(kill_all)) |-> $stable(rxl_q))
    else $error("receive length changed during response");
  irq_map_a: assert property (@(posedge clk) disable iff (rst)
    irq_err == (err_sum && iren_q[`LNUR_ST_ERR]) ##0 (!irq_comm || idok_q || rxok_q || txok_q))
    else $error("interrupt mapping wrong");

endmodule

// File: common/lnur_regs.svh
// register map, field positions, reset values and timing counts
`ifndef LNUR_REGS_SVH
`define LNUR_REGS_SVH
`define LNUR_A_CTRL 3'h0
`define LNUR_A_STAT 3'h1
`define LNUR_A_IREN 3'h2
`define LNUR_A_ERR 3'h3
`define LNUR_A_BTIM 3'h4
`define LNUR_A_LEN 3'h5
`define LNUR_A_PID 3'h6
`define LNUR_A_DATA 3'h7
`define LNUR_CTRL_SWRES 7
`define LNUR_CTRL_PROTO 6
`define LNUR_CTRL_ENA 3
`define LNUR_ST_BUSY 4
`define LNUR_ST_ERR 3
`define LNUR_ST_IDOK 2
`define LNUR_ST_TXOK 1
`define LNUR_ST_RXOK 0
`define LNUR_BT_DIS 7
`define LNUR_CMD_ABORT 3'h0
`define LNUR_CMD_TXHDR 3'h1
`define LNUR_CMD_RXRSP 3'h2
`define LNUR_CMD_TXRSP 3'h3
`define LNUR_E_BIT 0
`define LNUR_E_CKS 1
`define LNUR_E_PAR 2
`define LNUR_E_SYN 3
`define LNUR_E_FRM 4
`define LNUR_E_TO 5
`define LNUR_E_OVR 6
`define LNUR_E_ABT 7
`define LNUR_SPB_RST 6'h20
`define LNUR_PID_RST 8'h80
`define LNUR_MAX_LEN 4'h8
`define LNUR_CKS_GOOD 8'hff
`define LNUR_STOP_BIT 4'h9
`define LNUR_SMP_DIV 4'h4
`endif

// File: common/lnur_pkg.sv
// types of the lin/uart response and status block
package lnur_pkg;
  typedef enum logic [1:0] {
    LNUR_R_IDLE,
    LNUR_R_RX,
    LNUR_R_TX
  } lnur_rsp_e;
endpackage

// File: tb/lnur_bus_model.sv
// lin bus model: wired-and bus, remote node sender and frame capture
`timescale 1ns/1ps
module lnur_bus_model (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  int         bit_clks = 32;
  logic       drv      = 1'b1;
  logic [7:0] cap_b;
  logic [7:0] got      [$];
  // dominant low from either node wins; pull-up keeps the bus recessive
  assign rxd = txd & drv;
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
    drv <= 1'b1;
  endtask
  task automatic pull_low(input int n);
    drv <= 1'b0;
    repeat (n) @(posedge clk);
    drv <= 1'b1;
  endtask
  // mid-bit capture of what the block sends; no error checks here
  initial forever begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk);
      cap_b[i] = txd;
    end
    got.push_back(cap_b);
    repeat (bit_clks) @(posedge clk);
  end
endmodule

// File: tb/lnur_core_tb_top.sv
// self-checking bench of the lin/uart response and status block
`timescale 1ns/1ps
`include "lnur_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module lnur_core_tb_top;
  logic       clk          = 1'b0;
  logic       rst          = 1'b1;
  logic [2:0] addr         = 3'h0;
  logic [7:0] wdata        = 8'h00;
  logic       wr_en        = 1'b0;
  logic       rd_en        = 1'b0;
  logic       hdr_done     = 1'b0;
  logic [7:0] hdr_pid      = 8'h00;
  logic       sync_err_evt = 1'b0;
  logic       timeout_evt  = 1'b0;
  logic       brk_sync_evt = 1'b0;
  logic       resync_valid = 1'b0;
  logic       saw_hdr      = 1'b0;
  logic [7:0] rdata, rsp_tx_data, rsp_rx_data, rd_q;
  logic [2:0] rsp_idx, rsp_rx_idx;
  logic       txd, rxd, hdr_tx_start, rsp_rx_wr, irq_comm, irq_err;
  logic [7:0] tx_mem       [8];
  logic [7:0] rx_got       [8];
  int         failures     = 0;
  int         compares     = 0;
  always #2.5 clk = ~clk;
  assign rsp_tx_data = tx_mem[rsp_idx];
  always @(posedge clk) begin
    if (rsp_rx_wr === 1'b1) rx_got[rsp_rx_idx] <= rsp_rx_data;
    if (hdr_tx_start === 1'b1) saw_hdr <= 1'b1;
  end
  lnur_core dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .txd(txd), .rxd(rxd), .hdr_done(hdr_done), .hdr_pid(hdr_pid), .hdr_busy(1'b0),
    .sync_err_evt(sync_err_evt), .timeout_evt(timeout_evt), .brk_sync_evt(brk_sync_evt),
    .resync_valid(resync_valid), .resync_spb(6'h10), .hdr_tx_start(hdr_tx_start), .rsp_idx(rsp_idx),
    .rsp_tx_data(rsp_tx_data), .rsp_rx_data(rsp_rx_data), .rsp_rx_idx(rsp_rx_idx),
    .rsp_rx_wr(rsp_rx_wr), .irq_comm(irq_comm), .irq_err(irq_err));
  lnur_bus_model bus_u (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic print_verdict;
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // idle edge, so a following write never drives the strobe twice in one step
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    rd_q = rdata;
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_q, e)
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; n < 4000 && irq_comm !== 1'b1 && irq_err !== 1'b1; n++) @(posedge clk);
    `CHK(n < 4000, 1'b1)
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 500; n++) begin
      rd(`LNUR_A_STAT);
      if (rd_q[`LNUR_ST_BUSY] === 1'b0) break;
    end
    `CHK(n < 500, 1'b1)
  endtask
  task automatic hdr(input logic [7:0] p);
    hdr_pid  <= p;
    hdr_done <= 1'b1;
    @(posedge clk);
    hdr_done <= 1'b0;
  endtask
  task automatic start(input logic [7:0] p, input logic [7:0] len, input logic [7:0] cmd);
    hdr(p);
    wr(`LNUR_A_STAT, 8'h0f);
    wr(`LNUR_A_LEN, len);
    wr(`LNUR_A_CTRL, cmd);
  endtask
  function automatic logic [7:0] add8c(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h0, s[8]};
  endfunction
  function automatic logic [7:0] pid_of(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction
  task automatic t_reset_timing;
    chk_rd(`LNUR_A_BTIM, 8'h20);
    chk_rd(`LNUR_A_PID, 8'h80);
    chk_rd(`LNUR_A_LEN, 8'h00);
    `CHK({txd, irq_comm, irq_err}, 3'h4)
    wr(`LNUR_A_BTIM, 8'h08);
    chk_rd(`LNUR_A_BTIM, 8'h20);
    // eight samples per bit, the least software may program
    wr(`LNUR_A_BTIM, 8'h88);
    resync_valid <= 1'b1;
    @(posedge clk);
    resync_valid <= 1'b0;
    chk_rd(`LNUR_A_BTIM, 8'h88);
    wr(`LNUR_A_IREN, 8'h0f);
  endtask
  task automatic t_hdr;
    wr(`LNUR_A_CTRL, 8'h48);
    hdr(pid_of(6'h32));
    chk_rd(`LNUR_A_LEN, 8'h88);
    wr(`LNUR_A_IREN, 8'h0b);
    chk_rd(`LNUR_A_STAT, 8'h04);
    `CHK(irq_comm, 1'b0)
    wr(`LNUR_A_IREN, 8'h0f);
    hdr(pid_of(6'h05) ^ 8'h80);
    chk_rd(`LNUR_A_PID, pid_of(6'h05) ^ 8'h80);
    sync_err_evt <= 1'b1;
    @(posedge clk);
    sync_err_evt <= 1'b0;
    timeout_evt  <= 1'b1;
    @(posedge clk);
    timeout_evt  <= 1'b0;
    chk_rd(`LNUR_A_ERR, 8'h2c);
    wr(`LNUR_A_STAT, 8'h0f);
    wr(`LNUR_A_CTRL, 8'h08);
  endtask
  task automatic t_tx(input logic p13, input logic [3:0] len);
    logic [7:0] s;
    logic [3:0] n;
    n = (len > 4'h8) ? 4'h8 : len;
    s = p13 ? 8'h00 : pid_of(6'h12);
    for (int i = 0; i < n; i++) s = add8c(s, tx_mem[i]);
    bus_u.got.delete();
    start(pid_of(6'h12), {len, 4'h0}, {1'b0, p13, 6'h0b});
    wait_irq();
    `CHK(irq_comm, 1'b1)
    chk_rd(`LNUR_A_STAT, 8'h02);
    chk_rd(`LNUR_A_LEN, {n, n});
    chk_rd(`LNUR_A_CTRL, {1'b0, p13, 6'h08});
    `CHK(bus_u.got.size() == 32'(n) + 1, 1'b1)
    `CHK(bus_u.got[n], ~s)
  endtask
  task automatic t_rx(input logic bad);
    logic [7:0] s;
    s = add8c(add8c(pid_of(6'h21), 8'hc3), 8'h5a);
    start(pid_of(6'h21), 8'h02, 8'h0a);
    bus_u.send(8'hc3, 1'b1);
    bus_u.send(8'h5a, 1'b1);
    bus_u.send(~s ^ {7'h0, bad}, 1'b1);
    wait_irq();
    chk_rd(`LNUR_A_STAT, bad ? 8'h08 : 8'h01);
    chk_rd(`LNUR_A_ERR, {6'h0, bad, 1'b0});
    `CHK(irq_err, bad)
    chk_rd(`LNUR_A_CTRL, 8'h08);
    if (!bad) chk_rd(`LNUR_A_LEN, 8'h22);
    `CHK({rx_got[0], rx_got[1]}, 16'hc35a)
    wr(`LNUR_A_STAT, 8'h08);
    chk_rd(`LNUR_A_ERR, 8'h00);
    chk_rd(`LNUR_A_STAT, bad ? 8'h00 : 8'h01);
  endtask
  task automatic t_rxerr(input logic brk);
    start(pid_of(6'h21), 8'h02, 8'h0a);
    bus_u.send(8'hc3, 1'b1);
    if (brk) begin
      brk_sync_evt <= 1'b1;
      @(posedge clk);
      brk_sync_evt <= 1'b0;
    end else begin
      bus_u.send(8'h5a, 1'b0);
    end
    wait_irq();
    chk_rd(`LNUR_A_ERR, 8'h10);
    chk_rd(`LNUR_A_LEN, 8'h12);
    chk_rd(`LNUR_A_CTRL, 8'h08);
    wr(`LNUR_A_STAT, 8'h08);
  endtask
  task automatic t_busy;
    tx_mem[0] = 8'hff;
    start(pid_of(6'h12), 8'h10, 8'h0b);
    repeat (100) @(posedge clk);
    bus_u.pull_low(32);
    wait_irq();
    chk_rd(`LNUR_A_ERR, 8'h01);
    chk_rd(`LNUR_A_LEN, 8'h10);
    chk_rd(`LNUR_A_CTRL, 8'h08);
    start(pid_of(6'h12), 8'h10, 8'h0b);
    wr(`LNUR_A_CTRL, 8'h0a);
    chk_rd(`LNUR_A_ERR, 8'h40);
    wr(`LNUR_A_CTRL, 8'h00);
    start(pid_of(6'h12), 8'h10, 8'h0b);
    // abort first, then the header command once idle
    wr(`LNUR_A_CTRL, 8'h08);
    wait_idle();
    chk_rd(`LNUR_A_ERR, 8'h80);
    wr(`LNUR_A_STAT, 8'h08);
    wr(`LNUR_A_CTRL, 8'h09);
    for (int n = 0; n < 20 && saw_hdr !== 1'b1; n++) @(posedge clk);
    `CHK(saw_hdr, 1'b1)
    wr(`LNUR_A_CTRL, 8'h00);
  endtask
  task automatic t_uart;
    wr(`LNUR_A_STAT, 8'h0f);
    wr(`LNUR_A_CTRL, 8'h0f);
    wr(`LNUR_A_LEN, 8'h55);
    chk_rd(`LNUR_A_LEN, 8'h00);
    hdr(pid_of(6'h01));
    bus_u.send(8'ha5, 1'b1);
    wait_irq();
    chk_rd(`LNUR_A_STAT, 8'h01);
    chk_rd(`LNUR_A_DATA, 8'ha5);
    // transmit only, so the echo does not raise the receive flag first
    wr(`LNUR_A_CTRL, 8'h0e);
    bus_u.got.delete();
    wr(`LNUR_A_DATA, 8'h3c);
    wait_irq();
    chk_rd(`LNUR_A_STAT, 8'h02);
    `CHK(bus_u.got[0], 8'h3c)
  endtask
  initial begin
    for (int i = 0; i < 8; i++) tx_mem[i] = 8'(i * 37 + 5);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_timing();
    t_hdr();
    t_tx(1'b0, 4'h2);
    t_tx(1'b0, 4'h0);
    t_tx(1'b0, 4'hf);
    t_tx(1'b1, 4'h2);
    t_rx(1'b0);
    t_rx(1'b1);
    t_rxerr(1'b0);
    t_rxerr(1'b1);
    t_busy();
    t_uart();
    print_verdict();
  end
  // whole run needs some 10k cycles; the margin covers slow answers
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
